// ==== nvm_cfg.svh ====
// Constants of the two-wire nonvolatile command block.
// Assumes a 40 MHz core clock; included by its bare name.
`ifndef NVM_CFG_SVH
`define NVM_CFG_SVH

// ============================================================
// Control byte
`define CODE_ARRAY    4'ha
`define CODE_SEC      4'hb

// ============================================================
// Address handling
`define SEC_RD_MASK   15'h007f
`define SEC_WR_MASK   15'h003f
`define ALL_MASK      15'h7fff
`define BUF_FULL      7'h40

// ============================================================
// Bit counter marks
`define BIT_LAST      4'h8
`define BIT_ACK       4'h9
`define BIT_NEXT      4'ha
`define BIT_FIRST     4'h1
`define BIT_ZERO      4'h0

// ============================================================
// Timing: per-byte program time and its cycle count
`define CLK_NS        25
`define BYTE_WR_NS    60000
`define BYTE_WR_CYC   ((`BYTE_WR_NS + `CLK_NS - 1) / `CLK_NS)

`endif

// ==== nvm_pkg.sv ====
// Types shared by the two-wire nonvolatile command block.
// Assumes nvm_cfg.svh is compiled alongside.
package nvm_pkg;

  // ============================================================
  // Bus engine states and byte phases
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_RX,
    ST_TX
  } bus_state_t;

  typedef enum logic [1:0] {
    PH_CTRL,
    PH_ADDR_HI,
    PH_ADDR_LO,
    PH_DATA
  } phase_t;

  // ============================================================
  // Whole state of the command engine
  typedef struct packed {
    bus_state_t       st;
    phase_t           ph;
    logic [3:0]       cnt;
    logic [7:0]       shreg;
    logic             ack_drv;
    logic             sec;
    logic             rd;
    logic [14:0]      ptr;
    logic [7:0]       hi;
    logic [14:0]      wr_start;
    logic [5:0]       widx;
    logic [6:0]       wcount;
    logic [63:0][7:0] wbuf;
    logic             locked;
    logic             prog;
    logic             prog_sec;
    logic [6:0]       left;
    logic [5:0]       off;
    logic [5:0]       bidx;
    logic [15:0]      tmr;
    logic             inc_at_stop;
    logic [14:0]      maddr;
    logic             msec;
    logic [7:0]       mwdata;
    logic             mwe;
    logic             wp_m;
    logic             wp_q;
  } core_t;

  // Synchroniser and line history state
  typedef struct packed {
    logic [4:0] s1;
    logic [4:0] s2;
    logic       scl_d;
    logic       sda_d;
  } sense_t;

endpackage

// ==== nvm_line_sense.sv ====
// Pin synchroniser with clock edge and START/STOP detection.
// Assumes asynchronous pins; all outputs follow the second stage.
`timescale 1ns/1ps
module nvm_line_sense (
  input  wire logic       core_clk,
  input  wire logic       sys_rst,
  input  wire logic [4:0] pins,
  output logic            scl_rise,
  output logic            scl_fall,
  output logic            start,
  output logic            stop,
  output logic            sda,
  output logic [2:0]      held
);
  import nvm_pkg::*;

  sense_t q;
  sense_t n;

  // ============================================================
  // Two-stage synchroniser, then history of clock and data
  always_comb begin
    n       = q;
    n.s1    = pins;
    n.s2    = q.s1;
    n.scl_d = q.s2[0];
    n.sda_d = q.s2[1];
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  // Edges and bus conditions seen on synchronised lines
  assign scl_rise = q.s2[0] & ~q.scl_d;
  assign scl_fall = ~q.s2[0] & q.scl_d;
  assign start    = q.s2[0] & q.scl_d & ~q.s2[1] & q.sda_d;
  assign stop     = q.s2[0] & q.scl_d & q.s2[1] & ~q.sda_d;
  assign sda      = q.s2[1];
  assign held     = q.s2[4:2];
endmodule

// ==== nvm_cmd_core.sv ====
// Two-wire slave command engine: writes, protection, polling, reads.
// Assumes an external array answers mem_rdata combinationally.
//
// Function
// - Security area: bytes 0-63 user writable, 64-127 factory, never written.
// - First executed security write locks the user bytes until reset.
// - Code 1011 selects security area, 1010 the array; same write flow.
// - At STOP the buffered bytes are programmed from the given address up.
// - Security writes use only the low six address bits.
// - More than 64 data bytes wrap the buffer over earliest bytes.
// - Security write pointer wraps inside the 64-byte area.
// - No acknowledge of the control byte while programming.
// - Protected write is acknowledged, starts nothing, keeps lock unused.
// - Suppressed write still loads and advances the pointer within page.
// - Bytes are programmed one after another, time per byte.
// - Protect input high blocks writes to array and security area.
// - Protect input sampled only at the STOP ending a write.
// - Direction bit one selects reads: current, random, sequential.
// - One pointer serves both array and security area.
// - Current read uses pointer; pointer rolls over to zero at top.
// - Read control byte acknowledged, then eight bits shifted out.
// - Repeated START aborts write but keeps the loaded pointer.
// - Master acknowledge and closing STOP each advance the pointer.
// - Control byte select bits must match the select straps.
// - Two address bytes follow; fifteen address bits are used.
// - Accepted bytes are acknowledged by pulling data low on clock nine.
`timescale 1ns/1ps
`include "nvm_cfg.svh"
module nvm_cmd_core #(
  parameter logic [15:0] BYTE_WR_CYCLES = 16'(`BYTE_WR_CYC)
) (
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  input  wire logic        wp_in,
  input  wire logic        select_strap_0,
  input  wire logic        select_strap_1,
  input  wire logic        select_strap_2,
  output logic [14:0]      mem_addr,
  output logic             mem_sec,
  output logic [7:0]       mem_wdata,
  output logic             mem_we,
  input  wire logic [7:0]  mem_rdata
);
  import nvm_pkg::*;

  core_t      q;
  core_t      n;
  logic       scl_rise;
  logic       scl_fall;
  logic       bus_start;
  logic       bus_stop;
  logic       sda_s;
  logic [2:0] held;
  logic       wp_s;
  logic [2:0] straps;
  logic       commit;
  logic       accept;

  // ============================================================
  // Pointer arithmetic
  function automatic logic [14:0] page_inc(input logic [14:0] p);
    page_inc = {p[14:6], 6'(p[5:0] + 6'h01)};
  endfunction

  function automatic logic [14:0] seq_inc(input logic [14:0] p);
    seq_inc = 15'(p + 15'h0001);
  endfunction

  // ============================================================
  // Pin synchronisers and bus condition detection
  nvm_line_sense u_sense (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .pins     ({select_strap_2, select_strap_1, select_strap_0,
                sda_in, scl_in}),
    .scl_rise (scl_rise),
    .scl_fall (scl_fall),
    .start    (bus_start),
    .stop     (bus_stop),
    .sda      (sda_s),
    .held     (held)
  );

  // Protect pin passes two state flip-flops; straps come synchronised
  assign wp_s   = q.wp_q;
  assign straps = held;

  // ============================================================
  // Byte decisions
  // STOP closing a write with data buffered starts a program cycle
  assign commit = bus_stop && q.st == ST_RX && q.ph == PH_DATA
                  && q.wcount != 7'h00;
  // Control byte accepted only on code, strap match and when not busy
  assign accept = q.ph != PH_CTRL ||
                  ((q.shreg[7:4] == `CODE_ARRAY ||
                    q.shreg[7:4] == `CODE_SEC) &&
                   q.shreg[3:1] == straps &&
                   !q.prog);

  // ============================================================
  // Next-state logic of the whole engine
  always_comb begin
    n       = q;
    n.mwe   = 1'b0;
    n.maddr = q.sec ? (q.ptr & `SEC_RD_MASK) : q.ptr;
    n.msec  = q.sec;
    // Protect pin synchroniser, first stage read only by the second
    n.wp_m  = wp_in;
    n.wp_q  = q.wp_m;
    // Program engine: one byte per timer expiry
    if (q.prog) begin
      if (q.tmr == 16'h0000) begin
        n.maddr  = {q.wr_start[14:6], q.off}
                   & (q.prog_sec ? `SEC_WR_MASK : `ALL_MASK);
        n.msec   = q.prog_sec;
        n.mwdata = q.wbuf[q.bidx];
        n.mwe    = 1'b1;
        n.off    = 6'(q.off + 6'h01);
        n.bidx   = 6'(q.bidx + 6'h01);
        n.left   = 7'(q.left - 7'h01);
        n.tmr    = 16'(BYTE_WR_CYCLES - 16'h0001);
        if (q.left == 7'h01) begin
          n.prog = 1'b0;
        end
      end else begin
        n.tmr = 16'(q.tmr - 16'h0001);
      end
    end
    // Bus conditions first, then clock edges
    if (bus_start) begin
      n.st      = ST_RX;
      n.ph      = PH_CTRL;
      n.cnt     = `BIT_ZERO;
      n.ack_drv = 1'b0;
      n.inc_at_stop = 1'b0;
    end else if (bus_stop) begin
      n.st      = ST_IDLE;
      n.ph      = PH_CTRL;
      n.ack_drv = 1'b0;
      n.inc_at_stop = 1'b0;
      if (q.inc_at_stop) begin
        n.ptr = seq_inc(q.ptr);
      end
      if (commit && !wp_s && !(q.sec && q.locked)) begin
        n.prog     = 1'b1;
        n.prog_sec = q.sec;
        n.left     = (q.wcount > `BUF_FULL) ? `BUF_FULL : q.wcount;
        n.off      = q.wr_start[5:0];
        n.bidx     = 6'h00;
        n.tmr      = 16'(BYTE_WR_CYCLES - 16'h0001);
        if (q.sec) begin
          n.locked = 1'b1;
        end
      end
    end else begin
      case (q.st)
        ST_RX: begin
          if (scl_rise && q.cnt < `BIT_LAST) begin
            n.shreg = {q.shreg[6:0], sda_s};
            n.cnt   = 4'(q.cnt + 4'h1);
          end else if (scl_fall && q.cnt == `BIT_LAST) begin
            n.cnt     = `BIT_ACK;
            n.ack_drv = accept;
            if (!accept) begin
              n.st = ST_IDLE;
            end
            case (q.ph)
              PH_CTRL: begin
                n.sec = q.shreg[7:4] == `CODE_SEC;
                n.rd  = q.shreg[0];
              end
              PH_ADDR_HI: begin
                n.hi = q.shreg;
              end
              PH_ADDR_LO: begin
                n.ptr      = {q.hi[6:0], q.shreg};
                n.wr_start = {q.hi[6:0], q.shreg};
                n.wcount   = 7'h00;
                n.widx     = 6'h00;
              end
              default: begin
                n.wbuf[q.widx] = q.shreg;
                n.widx = 6'(q.widx + 6'h01);
                if (q.wcount != `BUF_FULL) begin
                  n.wcount = 7'(q.wcount + 7'h01);
                end
                n.ptr = page_inc(q.ptr);
              end
            endcase
          end else if (scl_fall && q.cnt == `BIT_ACK) begin
            n.ack_drv = 1'b0;
            n.cnt     = `BIT_ZERO;
            case (q.ph)
              PH_CTRL: begin
                if (q.rd) begin
                  n.st      = ST_TX;
                  n.ack_drv = ~mem_rdata[7];
                  n.shreg   = {mem_rdata[6:0], 1'b0};
                  n.cnt     = `BIT_FIRST;
                end else begin
                  n.ph = PH_ADDR_HI;
                end
              end
              PH_ADDR_HI: n.ph = PH_ADDR_LO;
              default:    n.ph = PH_DATA;
            endcase
          end
        end
        ST_TX: begin
          if (scl_fall && q.cnt < `BIT_LAST) begin
            n.ack_drv = ~q.shreg[7];
            n.shreg   = {q.shreg[6:0], 1'b0};
            n.cnt     = 4'(q.cnt + 4'h1);
          end else if (scl_fall && q.cnt == `BIT_LAST) begin
            n.ack_drv = 1'b0;
            n.cnt     = `BIT_ACK;
          end else if (scl_rise && q.cnt == `BIT_ACK) begin
            if (!sda_s) begin
              n.ptr = seq_inc(q.ptr);
              n.cnt = `BIT_NEXT;
            end else begin
              n.st          = ST_IDLE;
              n.inc_at_stop = 1'b1;
            end
          end else if (scl_fall && q.cnt == `BIT_NEXT) begin
            n.ack_drv = ~mem_rdata[7];
            n.shreg   = {mem_rdata[6:0], 1'b0};
            n.cnt     = `BIT_FIRST;
          end
        end
        default: begin
          n.ack_drv = 1'b0;
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  // ============================================================
  // Outputs from state flip-flops; data line is open drain
  assign sda_out   = 1'b0;
  assign sda_oe    = q.ack_drv;
  assign mem_addr  = q.maddr;
  assign mem_sec   = q.msec;
  assign mem_wdata = q.mwdata;
  assign mem_we    = q.mwe;

  // ============================================================
  // Assertions
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  property p_busy_nack;
    q.prog && q.st == ST_RX && q.ph == PH_CTRL && scl_fall
      && q.cnt == `BIT_LAST && !bus_start && !bus_stop
      |=> !sda_oe && q.st == ST_IDLE;
  endproperty
  a_busy_nack: assert property (p_busy_nack)
    else $error("control byte acknowledged while busy");

  property p_wp_block;
    commit && wp_s && !q.prog |=> !q.prog && q.locked == $past(q.locked);
  endproperty
  a_wp_block: assert property (p_wp_block)
    else $error("protected write started a cycle");

  property p_commit_go;
    commit && !wp_s && !(q.sec && q.locked) |=> q.prog;
  endproperty
  a_commit_go: assert property (p_commit_go)
    else $error("write not started at stop");

  property p_sec_lock;
    q.prog && q.prog_sec |-> q.locked;
  endproperty
  a_sec_lock: assert property (p_sec_lock)
    else $error("security write without lock");

  property p_sec_range;
    mem_we && mem_sec |-> mem_addr[14:6] == 9'h000;
  endproperty
  a_sec_range: assert property (p_sec_range)
    else $error("security write outside user bytes");

  property p_byte_gap;
    mem_we |=> !mem_we [*8];
  endproperty
  a_byte_gap: assert property (p_byte_gap)
    else $error("program bytes too close");

  property p_page_wrap;
    q.st == ST_RX && q.ph == PH_DATA && scl_fall && q.cnt == `BIT_LAST
      && !bus_start && !bus_stop
      |=> q.ptr[14:6] == $past(q.ptr[14:6]);
  endproperty
  a_page_wrap: assert property (p_page_wrap)
    else $error("write pointer left its page");

  property p_seq_inc;
    q.st == ST_TX && scl_rise && q.cnt == `BIT_ACK && !sda_s
      && !bus_start && !bus_stop
      |=> q.ptr == seq_inc($past(q.ptr));
  endproperty
  a_seq_inc: assert property (p_seq_inc)
    else $error("pointer not advanced on master ack");

  property p_data_ack;
    q.st == ST_RX && q.ph != PH_CTRL && scl_fall && q.cnt == `BIT_LAST
      && !bus_start && !bus_stop
      |=> sda_oe ##1 sda_oe;
  endproperty
  a_data_ack: assert property (p_data_ack)
    else $error("accepted byte not acknowledged");

  c_sec_write: cover property (commit && q.sec && !wp_s && !q.locked);
  c_seq_read:  cover property (q.st == ST_TX && q.cnt == `BIT_NEXT);
  c_poll_nack: cover property (q.prog && q.st == ST_RX && !accept);
endmodule

// ==== nvm_bus_master.sv ====
// Behavioural two-wire bus master that drives the command block.
// Assumes the bench resolves the open-drain data wire with a pull-up.
`timescale 1ns/1ps
module nvm_bus_master #(
  parameter int HALF = 8
) (
  input  wire logic core_clk,
  output logic      scl,
  output logic      sda_drv,
  input  wire logic sda_line
);
  // ============================================================
  // Line idles released; clock stands still outside frames
  initial begin
    scl     = 1'b1;
    sda_drv = 1'b1;
  end

  // One third of a bus clock period
  task automatic hold();
    repeat (HALF) @(posedge core_clk);
  endtask

  // START, also a repeated START from a low clock
  task automatic start();
    sda_drv <= 1'b1;
    hold();
    scl <= 1'b1;
    hold();
    sda_drv <= 1'b0;
    hold();
    scl <= 1'b0;
    hold();
  endtask

  // STOP ends a command
  task automatic stop();
    sda_drv <= 1'b0;
    hold();
    scl <= 1'b1;
    hold();
    sda_drv <= 1'b1;
    hold();
  endtask

  // One clock; data set while low, wire sampled late in the high
  task automatic bit_xfer(input logic b, output logic r);
    sda_drv <= b;
    hold();
    scl <= 1'b1;
    hold();
    r = sda_line;
    scl <= 1'b0;
    hold();
  endtask

  // Byte out MSB first, wire released on the ninth clock
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_xfer(d[i], r);
    bit_xfer(1'b1, r);
    ack = ~r;
  endtask

  // Byte in; master acknowledge to continue, none on the last
  task automatic rbyte(input logic mack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_xfer(1'b1, d[i]);
    bit_xfer(~mack, r);
  endtask
endmodule

// ==== nvm_cmd_core_tb.sv ====
// Self-checking bench for the two-wire nonvolatile command block.
// Assumes nvm_cfg.svh, nvm_pkg and the bus master model are compiled.
`timescale 1ns/1ps
`include "nvm_cfg.svh"
module nvm_cmd_core_tb;
  import nvm_pkg::*;
  localparam logic [15:0] WCYC = 16'h0010;
  logic        core_clk = 1'b0;
  logic        sys_rst  = 1'b1;
  logic        wp_in    = 1'b0;
  logic [2:0]  strap    = 3'b101;
  logic        scl, sda_drv, sda_oe, sda_line, mem_sec, mem_we, sda_out;
  logic [14:0] mem_addr;
  logic [7:0]  mem_wdata, mem_rdata;
  logic [7:0]  arr [0:32767];
  logic [7:0]  sec [0:127];
  logic [23:0] wlog [$];
  int          wcyc [$];
  int          cyc = 0;
  int          n_fail = 0;
  int          checks = 0;

  // ============================================================
  // Clock, open-drain wire and memory behind the block
  always #12.5 core_clk = ~core_clk;
  assign sda_line  = sda_oe ? sda_out : sda_drv;
  assign mem_rdata = mem_sec ? sec[mem_addr[6:0]] : arr[mem_addr];

  nvm_bus_master i_nvm_bus_master (
    .core_clk (core_clk),
    .scl      (scl),
    .sda_drv  (sda_drv),
    .sda_line (sda_line)
  );

  nvm_cmd_core #(.BYTE_WR_CYCLES(WCYC)) i_nvm_cmd_core (
    .core_clk       (core_clk),
    .sys_rst        (sys_rst),
    .scl_in         (scl),
    .sda_in         (sda_line),
    .sda_out        (sda_out),
    .sda_oe         (sda_oe),
    .wp_in          (wp_in),
    .select_strap_0 (strap[0]),
    .select_strap_1 (strap[1]),
    .select_strap_2 (strap[2]),
    .mem_addr       (mem_addr),
    .mem_sec        (mem_sec),
    .mem_wdata      (mem_wdata),
    .mem_we         (mem_we),
    .mem_rdata      (mem_rdata)
  );

  // Cycle count, hang limit and program log
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      n_fail++;
      $display("Error %0t: run did not finish", $time);
      conclude();
    end
    if (mem_we === 1'b1) begin
      wlog.push_back({mem_sec, mem_addr, mem_wdata});
      wcyc.push_back(cyc);
      if (mem_sec) sec[mem_addr[6:0]] <= mem_wdata;
      else arr[mem_addr] <= mem_wdata;
    end
  end

  // ============================================================
  // Compare tasks
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %0t: byte %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_ack(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %0t: ack %b expected %b", $time, got, exp);
    end
  endtask

  task automatic chk_word(input logic [23:0] got, input logic [23:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %0t: value %h expected %h", $time, got, exp);
    end
  endtask

  // ============================================================
  // Bus sequences
  function automatic logic [7:0] cb(input logic [3:0] c, input logic rd);
    return {c, strap, rd};
  endfunction

  task automatic ctrl(input logic [7:0] b, input logic exp);
    logic a;
    i_nvm_bus_master.start();
    i_nvm_bus_master.wbyte(b, a);
    chk_ack(a, exp);
  endtask

  task automatic setp(input logic [3:0] c, input logic [14:0] ad);
    logic a;
    ctrl(cb(c, 1'b0), 1'b1);
    i_nvm_bus_master.wbyte({1'b0, ad[14:8]}, a);
    chk_ack(a, 1'b1);
    i_nvm_bus_master.wbyte(ad[7:0], a);
    chk_ack(a, 1'b1);
  endtask

  task automatic write(input logic [3:0] c, input logic [14:0] ad,
                       input int n, input logic [7:0] base);
    logic a;
    wlog.delete();
    wcyc.delete();
    setp(c, ad);
    for (int k = 0; k < n; k++) begin
      i_nvm_bus_master.wbyte(base + 8'(k), a);
      chk_ack(a, 1'b1);
    end
    i_nvm_bus_master.stop();
  endtask

  task automatic rd(input logic [3:0] c, input logic [14:0] ad, input int n);
    logic [7:0] d;
    logic [14:0] p;
    ctrl(cb(c, 1'b1), 1'b1);
    for (int k = 0; k < n; k++) begin
      p = ad + 15'(k);
      i_nvm_bus_master.rbyte(k < n - 1, d);
      chk_byte(d, c == `CODE_SEC ? sec[p[6:0]] : arr[p]);
    end
    i_nvm_bus_master.stop();
  endtask

  task automatic poll(input logic [3:0] c, output int np);
    logic a;
    np = 0;
    do begin
      i_nvm_bus_master.start();
      i_nvm_bus_master.wbyte(cb(c, 1'b0), a);
      np++;
    end while (!a && np < 200);
    i_nvm_bus_master.stop();
    chk_ack(a, 1'b1);
  endtask

  // ============================================================
  // Scenarios
  task automatic s_refuse();
    ctrl({4'h9, strap, 1'b0}, 1'b0);
    ctrl({`CODE_ARRAY, 3'b100, 1'b0}, 1'b0);
    i_nvm_bus_master.stop();
  endtask

  task automatic s_protect();
    wp_in <= 1'b1;
    write(`CODE_ARRAY, 15'h0200, 1, 8'h11);
    write(`CODE_SEC, 15'h0010, 3, 8'ha0);
    repeat (4 * WCYC) @(posedge core_clk);
    chk_word(24'(wlog.size()), 24'h0);
    ctrl(cb(`CODE_SEC, 1'b0), 1'b1);
    i_nvm_bus_master.stop();
    wp_in <= 1'b0;
    rd(`CODE_SEC, 15'h0013, 1);
  endtask

  task automatic s_secwr();
    int np;
    write(`CODE_SEC, 15'h00be, 3, 8'hc0);
    wp_in <= 1'b1;
    poll(`CODE_SEC, np);
    wp_in <= 1'b0;
    chk_word(24'(wlog.size()), 24'h3);
    chk_word(wlog[0], {1'b1, 15'h003e, 8'hc0});
    chk_word(wlog[2], {1'b1, 15'h0000, 8'hc2});
    chk_word(24'(wcyc[2] - wcyc[1]), 24'(WCYC));
    write(`CODE_SEC, 15'h0005, 2, 8'hd0);
    repeat (4 * WCYC) @(posedge core_clk);
    chk_word(24'(wlog.size()), 24'h0);
    setp(`CODE_SEC, 15'h003e);
    rd(`CODE_SEC, 15'h003e, 2);
  endtask

  task automatic s_wrap();
    int np;
    write(`CODE_ARRAY, 15'h0100, 66, 8'h00);
    poll(`CODE_ARRAY, np);
    chk_word(24'(np > 1), 24'h1);
    chk_word(24'(wlog.size()), 24'h40);
    for (int k = 0; k < 64; k++)
      chk_word(wlog[k], {1'b0, 15'h0100 + 15'(k),
                         8'(k < 2 ? 64 + k : k)});
  endtask

  task automatic s_reads();
    setp(`CODE_ARRAY, 15'h7ffe);
    rd(`CODE_ARRAY, 15'h7ffe, 3);
    rd(`CODE_ARRAY, 15'h0001, 1);
    setp(`CODE_SEC, 15'h0046);
    rd(`CODE_SEC, 15'h0046, 1);
    rd(`CODE_ARRAY, 15'h0047, 1);
  endtask

  // ============================================================
  // Verdict
  task automatic conclude();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Main sequence
  initial begin
    for (int i = 0; i < 32768; i++) arr[i] = 8'(i) ^ 8'h3c;
    for (int i = 0; i < 128; i++) sec[i] = 8'(i) + 8'h80;
    repeat (16) @(posedge core_clk);
    sys_rst <= 1'b0;
    repeat (6) @(posedge core_clk);
    s_refuse();
    s_protect();
    s_secwr();
    s_wrap();
    s_reads();
    conclude();
  end
endmodule
